// [common/fspc_pkg.sv]
/*
  Package for the flash self-program control block: register offsets,
  field positions, reset values, key pattern, mode codes and timing.
  Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
*/
// Functional notes
// RULE1 - Enabled flag ignores software ones; software zero clears it.
// RULE2 - Mode 000 write, 001 erase, 011 read, 110 unlock; others reserved.
// RULE3 - Software unlocks successfully before asking for erase or write.
// RULE4 - Setting trigger starts timer; on expiry hardware clears trigger.
// RULE5 - Key low bytes of pairs two to four must be 00, 0D, C3.
// RULE6 - Key high bytes of pairs two to four must be 04, 09, 40.
// RULE7 - Software selects unlock mode, sets trigger, then writes key quickly.
// RULE8 - Correct key in window sets enabled flag; wrong key leaves it clear.
// RULE9 - Program start begins erase or write; hardware clears it when done.
// RULE10 - Reads only allowed while read permit is high.
// RULE11 - Read start begins a read; hardware clears it when done.
// RULE12 - Software never sets program start, permit and read start together.
// RULE13 - Processor is stalled while a started operation runs; the code stalls it for erase, write and read but not for a buffer clear.
// RULE14 - Software waits for one operation to finish before the next.
// RULE15 - Writing 55 to chip reset key resets the whole chip.
// RULE16 - Buffer clear start clears the buffer; hardware clears bit after.
// RULE17 - Upper seven bits of buffer clear register read as zero.
// RULE18 - Clearing enabled flag disables erase and write at once.
// RULE19 - Software checks an erased page reads all 0000h, else re-erases.
// RULE20 - On write mismatch software clears buffer and rewrites the page.
// RULE21 - Writing first data high loads the word and increments the address.
// RULE22 - Address increment stops at word offset 11111b of the page.
// RULE23 - Buffer and page erase act on the page chosen by address 12:5.
// RULE24 - Finished write clears the write buffer automatically.
// RULE25 - Unlock timer length is a parameter in system clock cycles.
`default_nettype none
package fspc_pkg;
  // Register byte addresses
  localparam logic [5:0] FSPC_ADDR_LOW   = 6'h00;
  localparam logic [5:0] FSPC_ADDR_HIGH  = 6'h04;
  localparam logic [5:0] FSPC_D0_LOW     = 6'h08;
  localparam logic [5:0] FSPC_D0_HIGH    = 6'h0c;
  localparam logic [5:0] FSPC_D1_LOW     = 6'h10;
  localparam logic [5:0] FSPC_D1_HIGH    = 6'h14;
  localparam logic [5:0] FSPC_D2_LOW     = 6'h18;
  localparam logic [5:0] FSPC_D2_HIGH    = 6'h1c;
  localparam logic [5:0] FSPC_D3_LOW     = 6'h20;
  localparam logic [5:0] FSPC_D3_HIGH    = 6'h24;
  localparam logic [5:0] FSPC_OP_CTRL    = 6'h28;
  localparam logic [5:0] FSPC_RESET_KEY  = 6'h2c;
  localparam logic [5:0] FSPC_BUF_CLEAR  = 6'h30;
  // Control field positions
  localparam int FSPC_BIT_ENABLED  = 7;
  localparam int FSPC_BIT_MODE_LO  = 4;
  localparam int FSPC_BIT_TRIGGER  = 3;
  localparam int FSPC_BIT_PROGRAM  = 2;
  localparam int FSPC_BIT_PERMIT   = 1;
  localparam int FSPC_BIT_READ     = 0;
  localparam int FSPC_BIT_CLEAR    = 0;
  localparam logic [7:0] FSPC_REG_RESET = 8'h00;
  // Mode codes
  localparam logic [2:0] FSPC_MODE_WRITE  = 3'h0;
  localparam logic [2:0] FSPC_MODE_ERASE  = 3'h1;
  localparam logic [2:0] FSPC_MODE_READ   = 3'h3;
  localparam logic [2:0] FSPC_MODE_UNLOCK = 3'h6;
  // Unlock key, pairs two to four
  localparam logic [7:0] FSPC_KEY1_LO = 8'h00;
  localparam logic [7:0] FSPC_KEY2_LO = 8'h0d;
  localparam logic [7:0] FSPC_KEY3_LO = 8'hc3;
  localparam logic [7:0] FSPC_KEY1_HI = 8'h04;
  localparam logic [7:0] FSPC_KEY2_HI = 8'h09;
  localparam logic [7:0] FSPC_KEY3_HI = 8'h40;
  localparam logic [7:0] FSPC_CHIP_RESET_VALUE = 8'h55;
  localparam logic [4:0] FSPC_PAGE_LAST = 5'h1f;
  // Timing
  localparam int FSPC_CLK_HZ = 25000000;
  localparam int FSPC_UNLOCK_WINDOW_US = 100;
  localparam int FSPC_UNLOCK_CYCLES =
    FSPC_UNLOCK_WINDOW_US * (FSPC_CLK_HZ / 1000000);
  localparam int FSPC_PROGRAM_TIME_US = 2200;
  localparam int FSPC_PROGRAM_CYCLES =
    FSPC_PROGRAM_TIME_US * (FSPC_CLK_HZ / 1000000);
  localparam int FSPC_READ_CYCLES = 4;
  localparam int FSPC_CLEAR_CYCLES = 32;

  typedef enum logic [2:0] {
    FSPC_IDLE, FSPC_ERASE, FSPC_WRITE, FSPC_READ, FSPC_CLEAR
  } fspc_state_type;

  // Request to the flash array
  typedef struct packed {
    logic        erase;
    logic        write;
    logic        read;
    logic [12:0] addr;
  } fspc_flash_req_type;
endpackage
`default_nettype wire

// [core/fspc_top.sv]
/*
  Flash self-program control: Wishbone register file, unlock sequencer,
  page write buffer and operation sequencer for erase, write and read.
  Assumes the flash array accepts request flags held high for the whole
  operation and that the processor honours the stall output.
*/
`default_nettype none
module fspc_top
  import fspc_pkg::*;
#(
  parameter int UNLOCK_CYCLES  = fspc_pkg::FSPC_UNLOCK_CYCLES,
  parameter int PROGRAM_CYCLES = fspc_pkg::FSPC_PROGRAM_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [5:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output fspc_pkg::fspc_flash_req_type      flash_req_o,
  output logic      [15:0]                  flash_wdata_o,
  input  wire logic [15:0]                  flash_rdata_i,
  output logic                              cpu_stall_o,
  output logic                              chip_reset_o
);
  import fspc_pkg::*;

  logic [12:0] flash_addr;
  logic [7:0]  data_lo [4];
  logic [7:0]  data_hi [4];
  logic        enabled;
  logic [2:0]  mode;
  logic        trigger;
  logic        program_start;
  logic        read_permit;
  logic        read_start;
  logic        clear_start;
  logic [15:0] wbuf [32];
  logic [31:0] trigger_age;
  logic [31:0] unlock_count;
  logic [31:0] op_count;
  fspc_state_type state;
  logic        bus_write;
  logic        key_ok;
  logic        op_done;
  logic [7:0]  wbyte;

  function automatic logic is_reg(input logic [5:0] offset);
    return bus_write && (wb_adr_i == offset);
  endfunction

  assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                     && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign op_done = (state != FSPC_IDLE) && (op_count == 32'h0000_0001);

  // Key check on pairs two to four
  assign key_ok = (data_lo[1] == FSPC_KEY1_LO) &&    // RULE5
                  (data_lo[2] == FSPC_KEY2_LO) &&
                  (data_lo[3] == FSPC_KEY3_LO) &&
                  (data_hi[1] == FSPC_KEY1_HI) &&    // RULE6
                  (data_hi[2] == FSPC_KEY2_HI) &&
                  (data_hi[3] == FSPC_KEY3_HI);

  ////////////////////////////////////////////////////////////////////////
  // Bus acknowledge, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Read data mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        FSPC_ADDR_LOW:  wb_dat_o <= {24'h000000, flash_addr[7:0]};
        FSPC_ADDR_HIGH: wb_dat_o <= {27'h0000000, flash_addr[12:8]};
        FSPC_D0_LOW:    wb_dat_o <= {24'h000000, data_lo[0]};
        FSPC_D0_HIGH:   wb_dat_o <= {24'h000000, data_hi[0]};
        FSPC_D1_LOW:    wb_dat_o <= {24'h000000, data_lo[1]};
        FSPC_D1_HIGH:   wb_dat_o <= {24'h000000, data_hi[1]};
        FSPC_D2_LOW:    wb_dat_o <= {24'h000000, data_lo[2]};
        FSPC_D2_HIGH:   wb_dat_o <= {24'h000000, data_hi[2]};
        FSPC_D3_LOW:    wb_dat_o <= {24'h000000, data_lo[3]};
        FSPC_D3_HIGH:   wb_dat_o <= {24'h000000, data_hi[3]};
        FSPC_OP_CTRL:   wb_dat_o <= {24'h000000, enabled, mode, trigger,
                                     program_start, read_permit, read_start};
        FSPC_RESET_KEY: wb_dat_o <= 32'h0000_0000;
        FSPC_BUF_CLEAR: wb_dat_o <= {31'h00000000, clear_start}; // RULE17
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pair with auto increment on first data high writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_addr <= 13'h0000;
    end else if (is_reg(FSPC_ADDR_LOW)) begin
      flash_addr[7:0] <= wbyte;
    end else if (is_reg(FSPC_ADDR_HIGH)) begin
      flash_addr[12:8] <= wbyte[4:0];
    end else if (is_reg(FSPC_D0_HIGH) && enabled
                 && flash_addr[4:0] != FSPC_PAGE_LAST) begin // RULE22
      flash_addr <= flash_addr + 13'h0001;                   // RULE21
    end
  end

  // Data pairs; the first pair also takes the word a read returns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        data_lo[i] <= FSPC_REG_RESET;
        data_hi[i] <= FSPC_REG_RESET;
      end
    end else if (state == FSPC_READ && op_done) begin
      data_lo[0] <= flash_rdata_i[7:0];                // RULE11
      data_hi[0] <= flash_rdata_i[15:8];
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (is_reg(FSPC_D0_LOW + 6'(8 * i))) begin
          data_lo[i] <= wbyte;
        end
        if (is_reg(FSPC_D0_HIGH + 6'(8 * i))) begin
          data_hi[i] <= wbyte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write buffer, indexed by word offset within the page
  always_ff @(posedge clk_i) begin
    if (rst_i || (state == FSPC_CLEAR && op_done)               // RULE16
        || (state == FSPC_WRITE && op_done)) begin              // RULE24
      for (int i = 0; i < 32; i++) begin
        wbuf[i] <= 16'h0000;
      end
    end else if (is_reg(FSPC_D0_HIGH) && enabled) begin
      wbuf[flash_addr[4:0]] <= {wbyte, data_lo[0]};             // RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enabled flag and unlock trigger with procedure timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enabled <= 1'b0;
    end else if (is_reg(FSPC_OP_CTRL) && !wbyte[FSPC_BIT_ENABLED]) begin
      enabled <= 1'b0;                                 // RULE1 RULE18
    end else if (trigger && mode == FSPC_MODE_UNLOCK && key_ok) begin
      enabled <= 1'b1;                                 // RULE8
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger      <= 1'b0;
      unlock_count <= 32'h0000_0000;
    end else if (trigger) begin
      if (unlock_count <= 32'h0000_0001) begin
        trigger      <= 1'b0;                          // RULE4
        unlock_count <= 32'h0000_0000;
      end else begin
        unlock_count <= unlock_count - 32'h0000_0001;
      end
    end else if (is_reg(FSPC_OP_CTRL) && wbyte[FSPC_BIT_TRIGGER]) begin
      trigger      <= 1'b1;                            // RULE4
      unlock_count <= 32'(UNLOCK_CYCLES);              // RULE25
    end
  end

  // Cycles the trigger has stood high, for the expiry check
  always_ff @(posedge clk_i) begin
    if (rst_i || !trigger) begin
      trigger_age <= 32'h0000_0000;
    end else begin
      trigger_age <= trigger_age + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode, start bits and read permit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode          <= 3'h0;
      read_permit   <= 1'b0;
      program_start <= 1'b0;
      read_start    <= 1'b0;
    end else if (is_reg(FSPC_OP_CTRL) && state == FSPC_IDLE) begin
      mode        <= wbyte[FSPC_BIT_MODE_LO +: 3];     // RULE2
      read_permit <= wbyte[FSPC_BIT_PERMIT];           // RULE10
      // A start latches only if the same write keeps its gate open,
      // so a write that drops the flag or permit cannot leave it stuck
      program_start <= wbyte[FSPC_BIT_PROGRAM] && enabled
        && wbyte[FSPC_BIT_ENABLED]                     // RULE18
        && (wbyte[6:4] == FSPC_MODE_WRITE
            || wbyte[6:4] == FSPC_MODE_ERASE);         // RULE9 RULE2
      read_start <= wbyte[FSPC_BIT_READ]
        && wbyte[FSPC_BIT_PERMIT]
        && wbyte[6:4] == FSPC_MODE_READ;               // RULE10 RULE11
    end else if (op_done) begin
      program_start <= 1'b0;                           // RULE9
      read_start    <= 1'b0;                           // RULE11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_start <= 1'b0;
    end else if (state == FSPC_CLEAR && op_done) begin
      clear_start <= 1'b0;                             // RULE16
    end else if (is_reg(FSPC_BUF_CLEAR) && wbyte[FSPC_BIT_CLEAR]
                 && state == FSPC_IDLE) begin
      clear_start <= 1'b1;                             // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= FSPC_IDLE;
      op_count <= 32'h0000_0000;
    end else begin
      case (state)
        FSPC_IDLE: begin
          if (program_start && enabled && mode == FSPC_MODE_ERASE) begin
            state    <= FSPC_ERASE;                    // RULE23
            op_count <= 32'(PROGRAM_CYCLES);
          end else if (program_start && enabled) begin
            state    <= FSPC_WRITE;
            op_count <= 32'(PROGRAM_CYCLES);
          end else if (read_start && read_permit) begin
            state    <= FSPC_READ;                     // RULE10
            op_count <= 32'(FSPC_READ_CYCLES);
          end else if (clear_start) begin
            state    <= FSPC_CLEAR;
            op_count <= 32'(FSPC_CLEAR_CYCLES);
          end
        end
        FSPC_ERASE, FSPC_WRITE, FSPC_READ, FSPC_CLEAR: begin
          if (op_done) begin
            state <= FSPC_IDLE;
          end else begin
            op_count <= op_count - 32'h0000_0001;
          end
        end
        default: state <= FSPC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to flash array, processor and chip reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_req_o   <= '0;
      flash_wdata_o <= 16'h0000;
      cpu_stall_o   <= 1'b0;
    end else begin
      flash_req_o.erase <= (state == FSPC_ERASE);
      flash_req_o.write <= (state == FSPC_WRITE);
      flash_req_o.read  <= (state == FSPC_READ);
      flash_req_o.addr  <= flash_addr;                 // RULE23
      flash_wdata_o     <= wbuf[flash_addr[4:0]];
      cpu_stall_o <= (state == FSPC_ERASE || state == FSPC_WRITE
                      || state == FSPC_READ);          // RULE13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_reset_o <= 1'b0;
    end else begin
      chip_reset_o <= is_reg(FSPC_RESET_KEY)
                      && wbyte == FSPC_CHIP_RESET_VALUE; // RULE15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the unlock procedure and the enabled flag
  a_enable_set_only: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i)
    $rose(enabled) |-> $past(trigger) && $past(key_ok))
    else $error("enabled flag rose without valid key");
  a_enable_sw_one: assert property ( // RULE1
    @(posedge clk_i) disable iff (rst_i)
    is_reg(FSPC_OP_CTRL) && !enabled
    && !(trigger && mode == FSPC_MODE_UNLOCK && key_ok) |=> !enabled)
    else $error("software set the enabled flag");
  a_enable_clear_now: assert property ( // RULE1 RULE18
    @(posedge clk_i) disable iff (rst_i)
    is_reg(FSPC_OP_CTRL) && !wbyte[FSPC_BIT_ENABLED] |=> !enabled)
    else $error("enabled flag not cleared by software");
  a_key_accept: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i)
    trigger && mode == FSPC_MODE_UNLOCK && key_ok
    && !is_reg(FSPC_OP_CTRL) |=> enabled)
    else $error("correct key not accepted");
  a_trigger_timeout: assert property ( // RULE4 RULE25
    @(posedge clk_i) disable iff (rst_i)
    trigger |-> trigger_age < 32'(UNLOCK_CYCLES))
    else $error("trigger not cleared by timer");

  // Checks on the sequencer and the processor stall
  a_reserved_idle: assert property ( // RULE2 RULE9
    @(posedge clk_i) disable iff (rst_i)
    is_reg(FSPC_OP_CTRL) && state == FSPC_IDLE
    && wbyte[6:4] != FSPC_MODE_WRITE
    && wbyte[6:4] != FSPC_MODE_ERASE |=> !program_start)
    else $error("program start in wrong mode");
  a_program_gated: assert property ( // RULE18 RULE9
    @(posedge clk_i) disable iff (rst_i)
    $rose(state == FSPC_ERASE || state == FSPC_WRITE) |-> $past(enabled))
    else $error("erase or write while disabled");
  a_read_gated: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    $rose(state == FSPC_READ) |-> $past(read_permit))
    else $error("read ran without permit");
  a_stall_busy: assert property ( // RULE13
    @(posedge clk_i) disable iff (rst_i)
    state == FSPC_ERASE || state == FSPC_WRITE || state == FSPC_READ
    |=> cpu_stall_o)
    else $error("processor not stalled");
  a_read_capture: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    state == FSPC_READ && op_done
    |=> {data_hi[0], data_lo[0]} == $past(flash_rdata_i))
    else $error("read word not captured");
  a_program_done: assert property ( // RULE9 RULE24
    @(posedge clk_i) disable iff (rst_i)
    state == FSPC_WRITE && op_done
    |=> !program_start && wbuf[flash_addr[4:0]] == 16'h0000)
    else $error("program start or buffer not cleared");
  a_clear_done: assert property ( // RULE16
    @(posedge clk_i) disable iff (rst_i)
    state == FSPC_CLEAR && op_done |=> !clear_start && wbuf[0] == 16'h0000)
    else $error("buffer clear did not finish");

  // Checks on the address pair, the page, the bus and the chip reset
  a_addr_hold: assert property ( // RULE22
    @(posedge clk_i) disable iff (rst_i)
    is_reg(FSPC_D0_HIGH) && flash_addr[4:0] == FSPC_PAGE_LAST
    |=> flash_addr[4:0] == FSPC_PAGE_LAST)
    else $error("address passed page end");
  a_erase_page: assert property ( // RULE23
    @(posedge clk_i) disable iff (rst_i)
    state == FSPC_ERASE |=> flash_req_o.erase
    && flash_req_o.addr == $past(flash_addr))
    else $error("erase request off the page");
  a_clear_bits: assert property ( // RULE17
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i) == FSPC_BUF_CLEAR
    |-> wb_dat_o[31:1] == 31'h00000000)
    else $error("buffer clear upper bits set");
  a_chip_reset_key: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    is_reg(FSPC_RESET_KEY) && wbyte == FSPC_CHIP_RESET_VALUE
    |=> chip_reset_o)
    else $error("chip reset not generated");
  a_chip_reset_only: assert property ( // RULE15
    @(posedge clk_i) disable iff (rst_i)
    !(is_reg(FSPC_RESET_KEY) && wbyte == FSPC_CHIP_RESET_VALUE)
    |=> !chip_reset_o)
    else $error("chip reset without its value");
endmodule
`default_nettype wire

// [test/fspc_flash_model.sv]
/*
  Behavioural flash array facing the self-program control block.
  Assumes each request flag stays high for the whole operation.
*/
`default_nettype none
module fspc_flash_model
  import fspc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire fspc_pkg::fspc_flash_req_type req_i,
  input  wire logic [15:0]             wdata_i,
  output logic      [15:0]             rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:8191];
  logic [15:0] last = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // Erase blanks the page chosen by the upper address bits
  always @(posedge clk_i) begin
    if (req_i.erase) begin
      for (int i = 0; i < 32; i++) begin
        mem[{req_i.addr[12:5], i[4:0]}] <= 16'h0000;
      end
    end
    if (req_i.write) begin
      mem[req_i.addr] <= wdata_i;
    end
  end
  // Read data only during a read; a changing pattern otherwise
  always @(posedge clk_i) begin
    if (req_i.read) begin
      rdata_o <= mem[req_i.addr];
    end else begin
      rdata_o <= ~last;
      last    <= ~last;
    end
  end
endmodule
`default_nettype wire

// [test/fspc_top_tb.sv]
/*
  Self-checking bench for the flash self-program control block.
  Assumes the flash model beside it and shortened unlock and program counts.
*/
`default_nettype none
module fspc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fspc_pkg::*;
  localparam int UNL = 40;
  localparam int PRG = 10;
  localparam logic [47:0] GOOD = {FSPC_KEY1_LO, FSPC_KEY2_LO, FSPC_KEY3_LO,
    FSPC_KEY1_HI, FSPC_KEY2_HI, FSPC_KEY3_HI};
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [5:0]         adr = 6'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        dat = 32'h0;
  logic [31:0]        rdo;
  logic               ack;
  fspc_flash_req_type req;
  logic [15:0]        wdat;
  logic [15:0]        rdat;
  logic               stall;
  logic               chip_rst;
  logic [31:0]        lfsr = 32'h1038;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  int                 stall_cnt = 0;
  int                 rst_cnt = 0;
  int                 op_cnt [3] = '{0, 0, 0};
  // Reserved mode codes, which must not start a program cycle
  logic [2:0]         m_codes [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchers of the stall, the chip reset and the flash requests
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (stall === 1'b1) stall_cnt++;
    if (chip_rst === 1'b1) rst_cnt++;
    if (req.erase === 1'b1) op_cnt[0]++;
    if (req.write === 1'b1) op_cnt[1]++;
    if (req.read === 1'b1) op_cnt[2]++;
  end
  fspc_top #(.UNLOCK_CYCLES(UNL), .PROGRAM_CYCLES(PRG)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdo), .wb_ack_o(ack), .flash_req_o(req),
    .flash_wdata_o(wdat), .flash_rdata_i(rdat), .cpu_stall_o(stall),
    .chip_reset_o(chip_rst));
  fspc_flash_model i_flash (.clk_i(clk_i), .req_i(req), .wdata_i(wdat),
    .rdata_o(rdat));
  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [12:0] exp_addr(input logic [12:0] a, input int n);
    int o;
    o = int'(a[4:0]) + n;
    if (o > 31) o = 31;
    return {a[12:5], o[4:0]};
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdo[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // Poll until the given bits fall, bounded
  task automatic wait_clear(input logic [5:0] a, input logic [7:0] m);
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h00, q);
      n++;
    end while ((q & m) !== 8'h00 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic unlock(input logic [47:0] k);
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_UNLOCK, 4'h0});
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_UNLOCK, 4'h8});
    wr(FSPC_D1_LOW, k[47:40]);
    wr(FSPC_D2_LOW, k[39:32]);
    wr(FSPC_D3_LOW, k[31:24]);
    wr(FSPC_D1_HIGH, k[23:16]);
    wr(FSPC_D2_HIGH, k[15:8]);
    wr(FSPC_D3_HIGH, k[7:0]);
    wait_clear(FSPC_OP_CTRL, 8'h08);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [12:0] a;
    logic [12:0] ea;
    logic [15:0] w;
    int sc;
    int oc;
    int rc;
    logic [2:0] m;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++) rd(6'(i * 4), 8'h00);
    wr(FSPC_OP_CTRL, 8'h80);
    rd(FSPC_OP_CTRL, 8'h00);
    $display("reset values and enable flag done");
    lfsr = next_rand(lfsr);
    unlock(GOOD ^ {lfsr, lfsr[15:1], 1'b1});
    rd(FSPC_OP_CTRL, {1'b0, FSPC_MODE_UNLOCK, 4'h0});
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_ERASE, 4'h4});
    rd(FSPC_OP_CTRL, {1'b0, FSPC_MODE_ERASE, 4'h0});
    unlock(GOOD);
    rd(FSPC_OP_CTRL, {1'b1, FSPC_MODE_UNLOCK, 4'h0});
    $display("unlock done");
    lfsr = next_rand(lfsr);
    a = {lfsr[12:5], 5'h1e};
    wr(FSPC_ADDR_LOW, a[7:0]);
    wr(FSPC_ADDR_HIGH, {3'h0, a[12:8]});
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      w = lfsr[15:0];
      wr(FSPC_D0_LOW, w[7:0]);
      wr(FSPC_D0_HIGH, w[15:8]);
    end
    ea = exp_addr(a, 3);
    rd(FSPC_ADDR_LOW, ea[7:0]);
    rd(FSPC_ADDR_HIGH, {3'h0, ea[12:8]});
    chk(wdat, w);
    $display("buffer load done");
    foreach (m_codes[i]) begin
      m = m_codes[i];
      wr(FSPC_OP_CTRL, {1'b1, m, 4'h4});
      rd(FSPC_OP_CTRL, {1'b1, m, 4'h0});
    end
    for (int i = 0; i < 2; i++) begin
      sc = stall_cnt;
      oc = op_cnt[i];
      wr(FSPC_OP_CTRL, {1'b1, (i == 0) ? FSPC_MODE_ERASE : FSPC_MODE_WRITE,
        4'h4});
      wait_clear(FSPC_OP_CTRL, 8'h04);
      chk({15'h0, (stall_cnt - sc) >= PRG}, 16'h0001);
      chk({15'h0, (op_cnt[i] - oc) >= PRG}, 16'h0001);
    end
    chk(wdat, 16'h0000);
    $display("erase and write done");
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_ERASE, 4'h0});
    sc = stall_cnt;
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_ERASE, 4'h4});
    rd(FSPC_OP_CTRL, {1'b0, FSPC_MODE_ERASE, 4'h0});
    chk(16'(stall_cnt - sc), 16'h0000);
    oc = op_cnt[2];
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_READ, 4'h1});
    rd(FSPC_OP_CTRL, {1'b0, FSPC_MODE_READ, 4'h0});
    chk(16'(op_cnt[2] - oc), 16'h0000);
    wr(FSPC_D0_LOW, ~w[7:0]);
    wr(FSPC_D0_HIGH, ~w[15:8]);
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_READ, 4'h2});
    wr(FSPC_OP_CTRL, {1'b0, FSPC_MODE_READ, 4'h3});
    wait_clear(FSPC_OP_CTRL, 8'h01);
    chk({15'h0, op_cnt[2] > oc}, 16'h0001);
    rd(FSPC_D0_LOW, w[7:0]);
    rd(FSPC_D0_HIGH, w[15:8]);
    $display("disable and read done");
    wr(FSPC_BUF_CLEAR, 8'hff);
    rd(FSPC_BUF_CLEAR, 8'h01);
    wait_clear(FSPC_BUF_CLEAR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      rc = rst_cnt;
      wr(FSPC_RESET_KEY, (lfsr[7:0] == 8'h55) ? 8'h54 : lfsr[7:0]);
      repeat (3) @(posedge clk_i);
      chk(16'(rst_cnt - rc), 16'h0000);
    end
    rc = rst_cnt;
    wr(FSPC_RESET_KEY, FSPC_CHIP_RESET_VALUE);
    repeat (3) @(posedge clk_i);
    chk(16'(rst_cnt - rc), 16'h0001);
    $display("buffer clear and chip reset done");
    complete_run();
  end
endmodule
`default_nettype wire
